// ### tb/exec_unit_model.sv
// Purpose: Execution-unit model issuing operand and stack requests
// Assumes: One request per call, answer one cycle after it is taken
// Notes:   Released address and data fields show inverted values; kind and write flag stay stale
module exec_unit_model
    import mem_space_pkg::*;
(
    input  wire logic clk_i,        // Core clock
    output acc_kind_t acc_kind_o,   // Operand type
    output logic      acc_req_o,    // Access valid
    output logic [7:0] acc_addr_o,  // Operand address
    output logic      acc_wr_o,     // Write, else read
    output logic [7:0] acc_wdata_o, // Write data
    output stk_op_t   stk_op_o,     // Stack operation
    output logic [15:0] stk_wdata_o // Stack data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        acc_kind_o = ACC_DIRECT;
        acc_req_o = 1'b0;
        acc_addr_o = 8'h00;
        acc_wr_o = 1'b0;
        acc_wdata_o = 8'h00;
        stk_op_o = STK_NONE;
        stk_wdata_o = 16'h0000;
    end

    // Callers touch held special addresses and the unheld direct 0x90, reserved bits as 0
    task automatic acc(input acc_kind_t k, input logic [7:0] a,
                       input logic w, input logic [7:0] d);
        @(posedge clk_i);
        acc_req_o <= 1'b1;
        acc_kind_o <= k;
        acc_addr_o <= a;
        acc_wr_o <= w;
        acc_wdata_o <= d;
        @(posedge clk_i);
        acc_req_o <= 1'b0;
        acc_addr_o <= ~a;
        acc_wdata_o <= ~d;
        #1;
    endtask : acc

    task automatic stk(input stk_op_t op, input logic [15:0] d);
        @(posedge clk_i);
        stk_op_o <= op;
        stk_wdata_o <= d;
        @(posedge clk_i);
        stk_op_o <= STK_NONE;
        stk_wdata_o <= ~d;
        #1;
    endtask : stk
endmodule : exec_unit_model

// ### tb/test_core_memory_space_decode.sv
// Purpose: Self-checking bench for the core memory-space decoder
// Assumes: Answers are sampled 1 ns after the edge that registers them
// Notes:   Expected values are worked out by hand per scenario
module test_core_memory_space_decode
    import mem_space_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0, sys_rst_i = 1'b1;
    logic acc_req, acc_wr, acc_sfr_o, acc_ext_o, op_nop_o;
    logic rec_ovf_o, rec_unf_o, pm_wr_req = 1'b0, pm_wr_o, pm_rsvd_o;
    logic [7:0] acc_addr, acc_wdata, acc_rdata_o, sp_o, psw_o;
    logic [7:0] op = 8'h00, pm_wdata = 8'h00, pm_wdata_o;
    logic [15:0] stk_wdata, stk_rdata_o, br_target_o, pm_addr_o;
    logic [15:0] br_pc = 16'h0000, br_opnd = 16'h0000, pm_addr = 16'h0000;
    acc_kind_t acc_kind;
    stk_op_t stk_op;
    br_kind_t br_kind = BR_REL;
    int n_errors = 0, n_compared = 0, cyc = 0;

    exec_unit_model u_exe (.clk_i, .acc_kind_o(acc_kind),
        .acc_req_o(acc_req), .acc_addr_o(acc_addr), .acc_wr_o(acc_wr),
        .acc_wdata_o(acc_wdata), .stk_op_o(stk_op), .stk_wdata_o(stk_wdata));

    core_mem_decode DUT (.clk_i, .sys_rst_i, .acc_req_i(acc_req),
        .acc_kind_i(acc_kind), .acc_addr_i(acc_addr), .acc_wr_i(acc_wr),
        .acc_wdata_i(acc_wdata), .acc_rdata_o, .acc_sfr_o, .acc_ext_o,
        .stk_op_i(stk_op), .stk_wdata_i(stk_wdata), .stk_rdata_o, .sp_o,
        .psw_o, .rec_ovf_o, .rec_unf_o, .br_kind_i(br_kind),
        .br_pc_i(br_pc), .br_opnd_i(br_opnd), .br_target_o, .op_i(op),
        .op_nop_o, .pm_wr_req_i(pm_wr_req), .pm_addr_i(pm_addr),
        .pm_wdata_i(pm_wdata), .pm_wr_o, .pm_addr_o, .pm_wdata_o,
        .pm_rsvd_o);

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // The whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic cmp_val(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val

    task automatic cmp_flag(input string nm, input logic e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_flag

    task automatic wr(input acc_kind_t k, input logic [7:0] a, d);
        u_exe.acc(k, a, 1'b1, d);
    endtask : wr

    task automatic rd(input acc_kind_t k, input logic [7:0] a, e,
                      input string nm);
        u_exe.acc(k, a, 1'b0, 8'h00);
        cmp_val(nm, {8'h00, e}, {8'h00, acc_rdata_o});
    endtask : rd

    task automatic stk(input stk_op_t o, input logic [15:0] d,
                       input logic [7:0] e);
        u_exe.stk(o, d);
        cmp_val("stack_top_pointer", {8'h00, e}, {8'h00, sp_o});
    endtask : stk

    task automatic t_reset();
        cmp_val("stack_top_pointer", 16'h0007, {8'h00, sp_o});
        rd(ACC_DIRECT, 8'h81, 8'h07, "pointer_by_address");
        cmp_flag("sfr_hit", 1'b1, acc_sfr_o);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_banks();
        wr(ACC_DIRECT, 8'hD0, 8'h10);
        wr(ACC_WREG, 8'h03, 8'hA3);
        rd(ACC_DIRECT, 8'h13, 8'hA3, "bank2_reg3");
        wr(ACC_WREG, 8'hFA, 8'h3C);
        rd(ACC_DIRECT, 8'h12, 8'h3C, "bank2_reg2");
        wr(ACC_BIT, 8'hD3, 8'h01);
        cmp_val("program_status_word", 16'h0018, {8'h00, psw_o});
        wr(ACC_WREG, 8'h00, 8'h77);
        rd(ACC_DIRECT, 8'h18, 8'h77, "bank3_reg0");
        $display("t_banks done");
    endtask : t_banks

    task automatic t_indirect();
        wr(ACC_DIRECT, 8'h19, 8'h90);
        wr(ACC_INDIRECT, 8'h01, 8'h5C);
        wr(ACC_DIRECT, 8'h90, 8'hFF);
        rd(ACC_INDIRECT, 8'h01, 8'h5C, "upper_ram");
        cmp_flag("sfr_hit", 1'b0, acc_sfr_o);
        wr(ACC_DIRECT, 8'h18, 8'h7F);
        wr(ACC_DIRECT, 8'h7F, 8'hE1);
        rd(ACC_INDIRECT, 8'h00, 8'hE1, "lower_ram");
        rd(ACC_DIRECT, 8'h7F, 8'hE1, "lower_ram");
        cmp_flag("sfr_hit", 1'b0, acc_sfr_o);
        $display("t_indirect done");
    endtask : t_indirect

    task automatic t_bits();
        wr(ACC_DIRECT, 8'h22, 8'h00);
        wr(ACC_BIT, 8'h13, 8'h01);
        rd(ACC_DIRECT, 8'h22, 8'h08, "bit_area_byte");
        rd(ACC_DIRECT, 8'h13, 8'hA3, "byte_13");
        wr(ACC_DIRECT, 8'h2F, 8'h80);
        rd(ACC_BIT, 8'h7F, 8'h01, "last_bit");
        $display("t_bits done");
    endtask : t_bits

    task automatic t_stack();
        stk(STK_PUSH, 16'h0055, 8'h08);
        rd(ACC_DIRECT, 8'h08, 8'h55, "pushed_byte");
        stk(STK_POP, 16'h0000, 8'h07);
        cmp_val("popped", 16'h0055, stk_rdata_o);
        wr(ACC_DIRECT, 8'h81, 8'hFF);
        stk(STK_PUSH, 16'h00AB, 8'h00);
        stk(STK_DEC, 16'h0000, 8'hFF);
        stk(STK_CALL, 16'h1234, 8'h01);
        rd(ACC_DIRECT, 8'h00, 8'h34, "call_low_byte");
        stk(STK_RET, 16'h0000, 8'hFF);
        cmp_val("return_address", 16'h1234, stk_rdata_o);
        $display("t_stack done");
    endtask : t_stack

    task automatic t_record();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        stk(STK_POP, 16'h0000, 8'h06);
        cmp_flag("record_underflow", 1'b1, rec_unf_o);
        for (int i = 0; i < 16; i++) begin
            stk(STK_CALL, 16'h0100, 8'h08 + 8'(2 * i));
            cmp_flag("record_overflow", 1'b0, rec_ovf_o);
        end
        stk(STK_PUSH, 16'h0000, 8'h27);
        cmp_flag("record_overflow", 1'b1, rec_ovf_o);
        for (int i = 0; i < 16; i++) begin
            stk(STK_RET, 16'h0000, 8'h25 - 8'(2 * i));
            cmp_flag("record_underflow", 1'b0, rec_unf_o);
        end
        stk(STK_DEC, 16'h0000, 8'h06);
        cmp_flag("record_underflow", 1'b1, rec_unf_o);
        $display("t_record done");
    endtask : t_record

    task automatic brn(input br_kind_t k, input logic [15:0] pc, o, e);
        @(posedge clk_i);
        br_kind <= k;
        br_pc <= pc;
        br_opnd <= o;
        @(posedge clk_i);
        #1;
        cmp_val("branch_target", e, br_target_o);
    endtask : brn

    task automatic t_branch();
        brn(BR_REL, 16'h1000, 16'h0080, 16'h0F80);
        brn(BR_REL, 16'h1000, 16'hFF7F, 16'h107F);
        brn(BR_PAGE, 16'h1802, 16'hF923, 16'h1923);
        brn(BR_LONG, 16'h0000, 16'h1FFF, 16'h1FFF);
        $display("t_branch done");
    endtask : t_branch

    task automatic t_opcode();
        logic [7:0] ops[3] = '{8'hA5, 8'h00, 8'h01};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            op <= ops[i];
            @(posedge clk_i);
            #1;
            cmp_flag("no_operation", i < 2, op_nop_o);
        end
        $display("t_opcode done");
    endtask : t_opcode

    task automatic pmw(input logic [15:0] a, input logic e, r);
        @(posedge clk_i);
        pm_wr_req <= 1'b1;
        pm_addr <= a;
        pm_wdata <= a[7:0];
        @(posedge clk_i);
        pm_wr_req <= 1'b0;
        #1;
        cmp_flag("program_write", e, pm_wr_o);
        cmp_flag("reserved_flag", r, pm_rsvd_o);
        if (e) cmp_val("program_addr", a, pm_addr_o);
        if (e) cmp_val("program_data", {8'h00, a[7:0]}, {8'h00, pm_wdata_o});
    endtask : pmw

    task automatic t_progstore();
        pmw(16'h0100, 1'b0, 1'b0);
        wr(ACC_DIRECT, 8'h8F, 8'h01);
        rd(ACC_DIRECT, 8'h8F, 8'h01, "program_store_control");
        pmw(16'h207F, 1'b1, 1'b0);
        pmw(16'h2080, 1'b0, 1'b0);
        pmw(16'h1E00, 1'b1, 1'b1);
        $display("t_progstore done");
    endtask : t_progstore

    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_banks();
        t_indirect();
        t_bits();
        t_stack();
        t_record();
        t_branch();
        t_opcode();
        t_progstore();
        results();
    end
endmodule : test_core_memory_space_decode

// ### verilog/core_mem_decode.sv
// Purpose: Operand decode, data RAM, stack pointer and stack record
// Assumes: Requests come from the execution unit on clk_i, one per cycle
// Notes:   Read data, targets and strobes appear one cycle after request
// Function
// - Working register picked within active bank only
// - Indirect pointer comes from bank R0/R1
// - Relative offset signed, added to next address
// - Direct low half RAM, upper half SFR
// - Page targets keep upper next-address bits
// - Long targets take full 16-bit address
// - Spare opcode behaves as no-operation
// - Program store spans zero through top address
// - Program writes need the write enable bit
// - Lower RAM reachable directly and indirectly
// - Upper indirect is RAM, upper direct SFR
// - Status bits pick bank base times eight
// - Bit area maps bytes 0x20 to 0x2F
// - Bit versus byte chosen by operand type
// - Push stores at pointer plus one
// - Reset loads stack pointer with 0x07
// - Record shifts one per push, two per call
// - Record flags overflow and underflow
// - SFR rows at 0 or 8 bit-addressable
// - Stack pointer lives at direct 0x81
module core_mem_decode
    import mem_space_pkg::*;
(
    input  wire logic      clk_i,       // Core clock
    input  wire logic      sys_rst_i,   // Sync reset, high
    input  wire logic      acc_req_i,   // Data access request
    input  wire acc_kind_t acc_kind_i,  // Operand type
    input  wire logic [7:0] acc_addr_i, // Operand address
    input  wire logic      acc_wr_i,    // Write, else read
    input  wire logic [7:0] acc_wdata_i,// Write data, bit in [0]
    output logic [7:0]     acc_rdata_o, // Read data
    output logic           acc_sfr_o,   // Access went to SFR space
    output logic           acc_ext_o,   // SFR not held here
    input  wire stk_op_t   stk_op_i,    // Stack operation
    input  wire logic [15:0] stk_wdata_i,// Push byte / call address
    output logic [15:0]    stk_rdata_o, // Pop byte / return address
    output logic [7:0]     sp_o,        // Stack pointer
    output logic [7:0]     psw_o,       // Status word
    output logic           rec_ovf_o,   // Record overflow pulse
    output logic           rec_unf_o,   // Record underflow pulse
    input  wire br_kind_t  br_kind_i,   // Branch kind
    input  wire logic [15:0] br_pc_i,   // Next instruction address
    input  wire logic [15:0] br_opnd_i, // Offset or address field
    output logic [15:0]    br_target_o, // Branch target
    input  wire logic [7:0] op_i,       // Fetched opcode
    output logic           op_nop_o,    // Opcode is a no-operation
    input  wire logic      pm_wr_req_i, // External-move write
    input  wire logic [15:0] pm_addr_i, // Program address
    input  wire logic [7:0] pm_wdata_i, // Program write data
    output logic           pm_wr_o,     // Program store write strobe
    output logic [15:0]    pm_addr_o,   // Program write address
    output logic [7:0]     pm_wdata_o,  // Program write data
    output logic           pm_rsvd_o    // Write aimed at reserved range
);
    logic [7:0]       ram_ff [256];
    logic [7:0]       sp_ff;
    logic [7:0]       psw_ff;
    logic             pswe_ff;
    logic [REC_W-1:0] rec_ff;
    logic [CNT_W-1:0] rec_cnt_ff;
    logic [1:0]       bank;
    logic [7:0]       ptr_idx;
    logic [7:0]       tgt_idx;
    logic             tgt_sfr;
    logic             is_bit;
    logic [2:0]       bit_pos;
    logic [7:0]       sfr_rd;
    logic             sfr_local;
    logic [7:0]       cur;
    logic [7:0]       wbyte;
    logic [7:0]       nxt_rdata;
    logic             do_wr;
    logic [7:0]       sp_p1;
    logic [7:0]       sp_p2;
    logic [7:0]       sp_m1;
    logic [CNT_W-1:0] rec_n;
    logic             rec_in;
    logic             rec_out;

    assign bank    = psw_ff[PSW_BANK_HI:PSW_BANK_LO];
    assign ptr_idx = {3'h0, bank, 2'h0, acc_addr_i[0]};
    assign do_wr   = acc_req_i && acc_wr_i;
    assign sp_p1   = sp_ff + ONE_B;
    assign sp_p2   = sp_ff + TWO_B;
    assign sp_m1   = sp_ff - ONE_B;

    // Operand type and address bit 7 decide space; type alone decides bit/byte handling
    always_comb begin
        tgt_sfr = 1'b0;
        tgt_idx = acc_addr_i;
        is_bit  = 1'b0;
        bit_pos = acc_addr_i[2:0];
        case (acc_kind_i)
            ACC_DIRECT: begin
                tgt_sfr = acc_addr_i[7];
            end
            ACC_INDIRECT: begin
                tgt_idx = ram_ff[ptr_idx];
            end
            ACC_WREG: begin
                tgt_idx = {3'h0, bank, acc_addr_i[2:0]};
            end
            ACC_BIT: begin
                is_bit  = 1'b1;
                tgt_sfr = acc_addr_i[7];
                if (acc_addr_i[7]) begin
                    tgt_idx = {acc_addr_i[7:3], 3'h0};
                end else begin
                    tgt_idx = BITRAM_BASE + {4'h0, acc_addr_i[6:3]};
                end
            end
            default: begin
                tgt_sfr = 1'b0;
            end
        endcase
    end

    // Unheld SFR addresses read as zero; they belong to other blocks
    always_comb begin
        sfr_local = 1'b1;
        case (tgt_idx)
            SP_ADDR:    sfr_rd = sp_ff;
            PSW_ADDR:   sfr_rd = psw_ff;
            STORE_CTL_ADDR: sfr_rd = {7'h00, pswe_ff};
            default: begin
                sfr_rd    = 8'h00;
                sfr_local = 1'b0;
            end
        endcase
    end

    always_comb begin
        cur = tgt_sfr ? sfr_rd : ram_ff[tgt_idx];
        wbyte = acc_wdata_i;
        nxt_rdata = cur;
        if (is_bit) begin
            wbyte = cur;
            wbyte[bit_pos] = acc_wdata_i[0];
            nxt_rdata = {7'h00, cur[bit_pos]};
        end
    end

    // Stack ops are written last so they win a clash with an operand
    always_ff @(posedge clk_i) begin
        if (do_wr && !tgt_sfr) begin
            ram_ff[tgt_idx] <= wbyte;
        end
        case (stk_op_i)
            STK_PUSH: ram_ff[sp_p1] <= stk_wdata_i[7:0];
            STK_CALL: begin
                ram_ff[sp_p1] <= stk_wdata_i[7:0];
                ram_ff[sp_p2] <= stk_wdata_i[15:8];
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sp_ff <= SP_RST;
        end else begin
            case (stk_op_i)
                STK_PUSH, STK_INC: sp_ff <= sp_p1;
                STK_CALL:          sp_ff <= sp_p2;
                STK_POP, STK_DEC:  sp_ff <= sp_m1;
                STK_RET:           sp_ff <= sp_ff - TWO_B;
                default: begin
                    if (do_wr && tgt_sfr && tgt_idx == SP_ADDR) begin
                        sp_ff <= wbyte;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            psw_ff  <= PSW_RST;
            pswe_ff <= 1'b0;
        end else if (do_wr && tgt_sfr) begin
            if (tgt_idx == PSW_ADDR) begin
                psw_ff <= wbyte;
            end
            if (tgt_idx == STORE_CTL_ADDR) begin
                pswe_ff <= wbyte[STORE_WE_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_rdata_o <= 8'h00;
            acc_sfr_o   <= 1'b0;
            acc_ext_o   <= 1'b0;
            stk_rdata_o <= 16'h0000;
        end else begin
            acc_rdata_o <= acc_req_i ? nxt_rdata : 8'h00;
            acc_sfr_o   <= acc_req_i && tgt_sfr;
            acc_ext_o   <= acc_req_i && tgt_sfr && !sfr_local;
            case (stk_op_i)
                STK_POP: stk_rdata_o <= {8'h00, ram_ff[sp_ff]};
                STK_RET: stk_rdata_o <= {ram_ff[sp_ff], ram_ff[sp_m1]};
                default: stk_rdata_o <= 16'h0000;
            endcase
        end
    end

    // Record: calls shift in ones, pushes zeros, so depth is tracked
    always_comb begin
        rec_n   = '0;
        rec_in  = 1'b0;
        rec_out = 1'b0;
        case (stk_op_i)
            STK_PUSH, STK_INC: begin
                rec_n  = CNT_W'(1);
                rec_in = 1'b1;
            end
            STK_CALL: begin
                rec_n  = CNT_W'(2);
                rec_in = 1'b1;
            end
            STK_POP, STK_DEC: begin
                rec_n   = CNT_W'(1);
                rec_out = 1'b1;
            end
            STK_RET: begin
                rec_n   = CNT_W'(2);
                rec_out = 1'b1;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rec_ff     <= '0;
            rec_cnt_ff <= '0;
            rec_ovf_o  <= 1'b0;
            rec_unf_o  <= 1'b0;
        end else begin
            rec_ovf_o <= 1'b0;
            rec_unf_o <= 1'b0;
            if (rec_in) begin
                if (stk_op_i == STK_CALL) begin
                    rec_ff <= {rec_ff[REC_W-3:0], 2'b11};
                end else begin
                    rec_ff <= {rec_ff[REC_W-2:0], 1'b0};
                end
                if (rec_cnt_ff + rec_n > CNT_W'(REC_W)) begin
                    rec_ovf_o  <= 1'b1;
                    rec_cnt_ff <= CNT_W'(REC_W);
                end else begin
                    rec_cnt_ff <= rec_cnt_ff + rec_n;
                end
            end else if (rec_out) begin
                rec_ff <= rec_ff >> rec_n;
                if (rec_cnt_ff < rec_n) begin
                    rec_unf_o  <= 1'b1;
                    rec_cnt_ff <= '0;
                end else begin
                    rec_cnt_ff <= rec_cnt_ff - rec_n;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            br_target_o <= 16'h0000;
            op_nop_o    <= 1'b0;
        end else begin
            case (br_kind_i)
                BR_REL: br_target_o <= br_pc_i
                    + {{8{br_opnd_i[7]}}, br_opnd_i[7:0]};
                BR_PAGE: br_target_o <= {br_pc_i[15:PAGE_W],
                    br_opnd_i[PAGE_W-1:0]};
                default: br_target_o <= br_opnd_i;
            endcase
            op_nop_o <= (op_i == NOP_OP) || (op_i == SPARE_OP);
        end
    end

    // Out-of-range writes are dropped; reserved ones are only flagged
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pm_wr_o    <= 1'b0;
            pm_addr_o  <= 16'h0000;
            pm_wdata_o <= 8'h00;
            pm_rsvd_o  <= 1'b0;
        end else begin
            pm_wr_o    <= pm_wr_req_i && pswe_ff
                          && pm_addr_i <= PM_TOP;
            pm_addr_o  <= pm_addr_i;
            pm_wdata_o <= pm_wdata_i;
            pm_rsvd_o  <= pm_wr_req_i && pm_addr_i >= RSV_LO
                          && pm_addr_i <= RSV_HI;
        end
    end

    assign sp_o  = sp_ff;
    assign psw_o = psw_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_sp_reset: assert property (disable iff (1'b0)
        sys_rst_i |=> sp_ff == SP_RST) else $error("sp not reset");
    chk_push_store: assert property (
        stk_op_i == STK_PUSH |=> sp_ff == $past(sp_p1)
        && ram_ff[sp_ff] == $past(stk_wdata_i[7:0]))
        else $error("push order wrong");
    chk_wreg_bank: assert property (
        acc_kind_i == ACC_WREG |-> tgt_idx[7:5] == 3'h0
        && tgt_idx[4:3] == psw_ff[PSW_BANK_HI:PSW_BANK_LO])
        else $error("wreg outside bank");
    chk_indir_ram: assert property (
        acc_kind_i == ACC_INDIRECT |-> !tgt_sfr
        && tgt_idx == ram_ff[ptr_idx]) else $error("indirect wrong");
    chk_direct_split: assert property (
        acc_req_i && acc_kind_i == ACC_DIRECT |=>
        acc_sfr_o == $past(acc_addr_i[7])) else $error("direct split");
    chk_page_target: assert property (
        br_kind_i == BR_PAGE |=> br_target_o[15:PAGE_W]
        == $past(br_pc_i[15:PAGE_W])) else $error("page crossed");
    chk_spare_nop: assert property (
        op_i == SPARE_OP |=> op_nop_o) else $error("spare not nop");
    chk_pm_guard: assert property (
        pm_wr_o |-> $past(pswe_ff) && $past(pm_wr_req_i))
        else $error("pm write unguarded");
    chk_rec_ovf: assert property (
        rec_cnt_ff == CNT_W'(REC_W) && stk_op_i == STK_PUSH
        |=> rec_ovf_o) else $error("overflow missed");
    chk_rec_unf: assert property (
        rec_cnt_ff == '0 && stk_op_i == STK_RET
        |=> rec_unf_o) else $error("underflow missed");

    cov_call_ret: cover property (
        stk_op_i == STK_CALL ##[1:8] stk_op_i == STK_RET);
    cov_bit_sfr: cover property (
        acc_req_i && acc_kind_i == ACC_BIT && acc_addr_i[7]);
    cov_pm_write: cover property (pm_wr_o);
endmodule : core_mem_decode

// ### verilog/mem_space_pkg.sv
// Purpose: Shared constants and types for the core memory-space decoder
// Assumes: 8-bit data space, 16-bit program addresses
// Notes:   Special-function addresses are direct-space byte addresses
package mem_space_pkg;
    localparam logic [7:0]  SP_ADDR      = 8'h81;
    localparam logic [7:0]  PSW_ADDR     = 8'hD0;
    localparam logic [7:0]  STORE_CTL_ADDR = 8'h8F;
    localparam logic [7:0]  SP_RST       = 8'h07;
    localparam logic [7:0]  PSW_RST      = 8'h00;
    localparam logic [7:0]  NOP_OP       = 8'h00;
    localparam logic [7:0]  SPARE_OP     = 8'hA5;
    localparam logic [7:0]  BITRAM_BASE  = 8'h20;
    localparam logic [7:0]  ONE_B        = 8'h01;
    localparam logic [7:0]  TWO_B        = 8'h02;
    localparam logic [15:0] PM_TOP       = 16'h207F;
    localparam logic [15:0] RSV_LO       = 16'h1E00;
    localparam logic [15:0] RSV_HI       = 16'h1FFF;
    localparam int          PSW_BANK_LO  = 3;
    localparam int          PSW_BANK_HI  = 4;
    localparam int          STORE_WE_BIT = 0;
    localparam int          PAGE_W       = 11;
    localparam int          REC_W        = 32;
    localparam int          CNT_W        = 6;

    typedef enum logic [1:0] {
        ACC_DIRECT,
        ACC_INDIRECT,
        ACC_WREG,
        ACC_BIT
    } acc_kind_t;

    typedef enum logic [2:0] {
        STK_NONE,
        STK_PUSH,
        STK_POP,
        STK_CALL,
        STK_RET,
        STK_INC,
        STK_DEC
    } stk_op_t;

    typedef enum logic [1:0] {
        BR_REL,
        BR_PAGE,
        BR_LONG
    } br_kind_t;
endpackage : mem_space_pkg
